/* design/srop_pdm.v */
// First-order sigma-delta pulse-density modulator.
// Assumes level is stable between result updates; output low when idle.
`timescale 1ns/100ps
`default_nettype none

module srop_pdm #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input  wire             clock,
    input  wire             resetn,
    // Control and level
    input  wire             enable,
    input  wire [WIDTH-1:0] level,
    // Stream
    output reg              pdm_q
);

    reg  [WIDTH-1:0] acc_q;
    wire [WIDTH:0]   sum_d = {1'b0, acc_q} + {1'b0, level};

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            acc_q <= {WIDTH{1'b0}};
            pdm_q <= 1'b0;
        end else if (enable) begin
            // Carry out of the accumulator is the density bit
            acc_q <= sum_d[WIDTH-1:0];
            pdm_q <= sum_d[WIDTH];
        end else begin
            acc_q <= {WIDTH{1'b0}};
            pdm_q <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* design/srop_regs.vh */
// Constants for the sensor result output port: status byte layout,
// configuration word fields, command codes and widths.
// Included by the top design file of the block only.
`ifndef SROP_REGS_VH
`define SROP_REGS_VH

// General status byte bit positions
`define SROP_ST_UNUSED      7
`define SROP_ST_POWERED     6
`define SROP_ST_BUSY        5
`define SROP_ST_MODE_HI     4
`define SROP_ST_MODE_LO     3
`define SROP_ST_MEM_ERR     2
`define SROP_ST_ADC_OVF     1
`define SROP_ST_MATH_SAT    0

// Operating mode codes in status bits 4:3
`define SROP_MODE_NORMAL    2'h0
`define SROP_MODE_COMMAND   2'h1
`define SROP_MODE_TEST      2'h2

// Configuration word 02h fields
`define SROP_CFG_WORD       8'h02
`define SROP_CFG_ADDR_HI    6
`define SROP_CFG_ADDR_LO    0
`define SROP_CFG_DENS_EN    9

// Measurement command codes
`define SROP_CMD_MEASURE    8'hAA
`define SROP_CMD_RAW_SENS   8'hA2
`define SROP_CMD_RAW_TEMP   8'hA6

// Byte counts
`define SROP_CMD_MAX_BYTES  3
`define SROP_FULL_BYTES     3'h6
`define SROP_RAW_BYTES      3'h3

// Result limits and ADC resolution
`define SROP_RES_MAX        24'hFFFFFF
`define SROP_ADC_MIN_BITS   12
`define SROP_DENS_WIDTH     16

`endif

/* design/srop_sync.v */
// Two flip-flop synchroniser, one stage pair per bit.
// Assumes the inputs are asynchronous to clock; resets to the idle-high
// level of an open-drain bus.
`timescale 1ns/100ps
`default_nettype none

module srop_sync #(
    parameter WIDTH = 2
) (
    // Clock and reset
    input  wire             clock,
    input  wire             resetn,
    // Signals
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta_q;
            reg sync_q;
            always @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    meta_q <= 1'b1;
                    sync_q <= 1'b1;
                end else begin
                    meta_q <= async_in[i];
                    sync_q <= meta_q;
                end
            end
            assign sync_out[i] = sync_q;
        end
    endgenerate

endmodule

`default_nettype wire

/* design/srop_top.v */
// Result output port: two-wire slave that takes commands and returns the
// status byte and result words, plus the pulse-density output stage.
// Assumes the measurement core answers each command with one result_valid
// pulse and that the bus clock is several system clocks long per phase.
//
// Operation
// - Density output forces cyclic mode, no sleep
// - Density enable bit starts stream after reset
// - Stream carries compensated sensor, 16-bit scaled
// - Slave address loaded from config after reset
// - Read starts with status, then command data
// - Repeated reads same data; command invalidates
// - Status bit 7 always zero
// - Status bit 6 one while powered
// - Busy bit set; commands ignored while busy
// - Status bits 4:3 give operating mode
// - Status bit 2 flags memory checksum failure
// - Status bit 1 flags raw capacitive overflow
// - Status bit 0 flags last measurement saturation
// - Out-of-range results clamped and reported
// - Seven-bit addressing only, all speeds
// - Status readable anytime; master waits busy
// - Temperature result unsigned 0 to FFFFFF
// - Same commands on any interface type
// - Measure returns sensor then temperature word
`timescale 1ns/100ps
`default_nettype none
`include "srop_regs.vh"

module srop_top (
    // Clock and reset
    input  wire        clock,
    input  wire        resetn,
    // Two-wire bus pins
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         sda_out_q,
    output reg         sda_oe_q,
    // Configuration word 02h from non-volatile memory
    input  wire [15:0] cfg_word,
    // Core status inputs
    input  wire [1:0]  core_mode,
    input  wire        mem_error,
    input  wire [1:0]  adc_bits,
    // Core result inputs
    input  wire        result_valid,
    input  wire [25:0] sensor_value,
    input  wire [25:0] temp_value,
    input  wire [23:0] adc_raw,
    input  wire        raw_is_cap,
    input  wire        core_sat,
    // Command outputs to core
    output reg         cmd_valid_q,
    output reg  [7:0]  cmd_code_q,
    output reg  [15:0] cmd_arg_q,
    // Mode control and density stream
    output reg         cyclic_req_q,
    output reg         sleep_inhibit_q,
    output wire        density_out
);

    localparam ST_IDLE     = 3'h0;
    localparam ST_ADDR     = 3'h1;
    localparam ST_ADDR_ACK = 3'h2;
    localparam ST_RX       = 3'h3;
    localparam ST_RX_ACK   = 3'h4;
    localparam ST_TX       = 3'h5;
    localparam ST_TX_ACK   = 3'h6;

    // Pin synchronisation and bus events
    wire [1:0] pins_s;
    reg        scl_prev_q;
    reg        sda_prev_q;

    srop_sync #(.WIDTH(2)) u_sync (
        .clock    (clock),
        .resetn   (resetn),
        .async_in ({scl_in, sda_in}),
        .sync_out (pins_s)
    );

    wire scl_s    = pins_s[1];
    wire sda_s    = pins_s[0];
    wire scl_rise = scl_s & ~scl_prev_q;
    wire scl_fall = ~scl_s & scl_prev_q;
    wire bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    wire bus_stop  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    // State
    reg [2:0]  state_q;
    reg [3:0]  bit_cnt_q;
    reg [7:0]  rx_sh_q;
    reg [7:0]  tx_sh_q;
    reg        nack_q;
    reg [2:0]  rd_idx_q;
    reg [1:0]  rx_cnt_q;
    reg [23:0] rx_bytes_q;
    reg        wr_seen_q;
    reg [6:0]  slave_addr_q;
    reg        load_cfg_q;
    reg        dens_en_q;
    reg        busy_q;
    reg        data_valid_q;
    reg        meas_cmd_q;
    reg        full_cmd_q;
    reg [47:0] data_q;
    reg        adc_ovf_q;
    reg        math_sat_q;
    reg [15:0] dens_level_q;

    // Clamp a signed core value into the unsigned 24-bit result range
    function [24:0] clamp24;
        input [25:0] v;
        begin
            if (v[25])
                clamp24 = {1'b1, 24'h000000};
            else if (v[24])
                clamp24 = {1'b1, `SROP_RES_MAX};
            else
                clamp24 = {1'b0, v[23:0]};
        end
    endfunction

    wire [24:0] sens_c = clamp24(sensor_value);
    wire [24:0] temp_c = clamp24(temp_value);

    // Raw overflow: top bit of the selected resolution or any bit above it differs from sign
    reg     raw_ovf;
    integer n;
    integer i;
    always @* begin
        raw_ovf = 1'b0;
        n = `SROP_ADC_MIN_BITS + 2 * adc_bits;
        for (i = 0; i < 24; i = i + 1) begin
            if (i >= n - 1 && adc_raw[i] != adc_raw[23])
                raw_ovf = 1'b1;
        end
    end

    wire [7:0] status_byte;
    assign status_byte[`SROP_ST_UNUSED]   = 1'b0;
    assign status_byte[`SROP_ST_POWERED]  = 1'b1;
    assign status_byte[`SROP_ST_BUSY]     = busy_q;
    assign status_byte[`SROP_ST_MODE_HI:`SROP_ST_MODE_LO] = core_mode;
    assign status_byte[`SROP_ST_MEM_ERR]  = mem_error;
    assign status_byte[`SROP_ST_ADC_OVF]  = adc_ovf_q;
    assign status_byte[`SROP_ST_MATH_SAT] = math_sat_q;

    // Read byte order: status first, then held data
    reg [7:0] next_byte;
    always @* begin
        next_byte = 8'h00;
        if (data_valid_q) begin
            case (rd_idx_q)
                3'h1:    next_byte = data_q[47:40];
                3'h2:    next_byte = data_q[39:32];
                3'h3:    next_byte = data_q[31:24];
                3'h4:    next_byte = full_cmd_q ? data_q[23:16] : 8'h00;
                3'h5:    next_byte = full_cmd_q ? data_q[15:8] : 8'h00;
                3'h6:    next_byte = full_cmd_q ? data_q[7:0] : 8'h00;
                default: next_byte = 8'h00;
            endcase
        end
    end

    wire [7:0] first_code = rx_bytes_q[23:16];
    wire       code_meas  = (first_code == `SROP_CMD_MEASURE) |
                            (first_code == `SROP_CMD_RAW_SENS) |
                            (first_code == `SROP_CMD_RAW_TEMP);

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            scl_prev_q      <= 1'b1;
            sda_prev_q      <= 1'b1;
            state_q         <= ST_IDLE;
            bit_cnt_q       <= 4'h0;
            rx_sh_q         <= 8'h00;
            tx_sh_q         <= 8'h00;
            nack_q          <= 1'b0;
            rd_idx_q        <= 3'h0;
            rx_cnt_q        <= 2'h0;
            rx_bytes_q      <= 24'h000000;
            wr_seen_q       <= 1'b0;
            sda_out_q       <= 1'b0;
            sda_oe_q        <= 1'b0;
            slave_addr_q    <= 7'h00;
            load_cfg_q      <= 1'b1;
            dens_en_q       <= 1'b0;
            cyclic_req_q    <= 1'b0;
            sleep_inhibit_q <= 1'b0;
            busy_q          <= 1'b0;
            data_valid_q    <= 1'b0;
            meas_cmd_q      <= 1'b0;
            full_cmd_q      <= 1'b0;
            data_q          <= 48'h000000000000;
            adc_ovf_q       <= 1'b0;
            math_sat_q      <= 1'b0;
            dens_level_q    <= 16'h0000;
            cmd_valid_q     <= 1'b0;
            cmd_code_q      <= 8'h00;
            cmd_arg_q       <= 16'h0000;
        end else begin
            scl_prev_q  <= scl_s;
            sda_prev_q  <= sda_s;
            sda_out_q   <= 1'b0;
            cmd_valid_q <= 1'b0;

            // Address and enable caught once after reset release
            if (load_cfg_q) begin
                load_cfg_q   <= 1'b0;
                slave_addr_q <= cfg_word[`SROP_CFG_ADDR_HI:`SROP_CFG_ADDR_LO];
                dens_en_q    <= cfg_word[`SROP_CFG_DENS_EN];
            end
            // Density output keeps cyclic mode awake
            cyclic_req_q    <= dens_en_q;
            sleep_inhibit_q <= dens_en_q;

            // Result latch and busy release together
            if (result_valid && busy_q) begin
                busy_q       <= 1'b0;
                data_valid_q <= 1'b1;
                data_q       <= {sens_c[23:0], temp_c[23:0]};
                math_sat_q   <= meas_cmd_q &
                                (core_sat | sens_c[24] | temp_c[24]);
                adc_ovf_q    <= raw_is_cap & raw_ovf;
                if (full_cmd_q)
                    dens_level_q <= sens_c[23:8];
            end

            if (bus_start) begin
                state_q   <= ST_ADDR;
                bit_cnt_q <= 4'h0;
                rx_cnt_q  <= 2'h0;
                wr_seen_q <= 1'b0;
                sda_oe_q  <= 1'b0;
            end else if (bus_stop) begin
                state_q  <= ST_IDLE;
                sda_oe_q <= 1'b0;
                // Same command set on every interface
                if (wr_seen_q && rx_cnt_q != 2'h0 && !busy_q) begin
                    cmd_valid_q  <= 1'b1;
                    cmd_code_q   <= first_code;
                    cmd_arg_q    <= rx_bytes_q[15:0];
                    busy_q       <= 1'b1;
                    data_valid_q <= 1'b0;
                    meas_cmd_q   <= code_meas;
                    full_cmd_q   <= (first_code == `SROP_CMD_MEASURE);
                    math_sat_q   <= 1'b0;
                end
            end else begin
                case (state_q)
                    ST_ADDR, ST_RX: begin
                        if (scl_rise) begin
                            rx_sh_q   <= {rx_sh_q[6:0], sda_s};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall && bit_cnt_q == 4'h8) begin
                            bit_cnt_q <= 4'h0;
                            if (state_q == ST_ADDR) begin
                                if (rx_sh_q[7:1] == slave_addr_q) begin
                                    sda_oe_q <= 1'b1;
                                    nack_q   <= rx_sh_q[0];
                                    state_q  <= ST_ADDR_ACK;
                                end else begin
                                    state_q <= ST_IDLE;
                                end
                            end else begin
                                // Up to three command bytes kept
                                if (rx_cnt_q != `SROP_CMD_MAX_BYTES) begin
                                    rx_cnt_q   <= rx_cnt_q + 2'h1;
                                    if (rx_cnt_q == 2'h0)
                                        rx_bytes_q <= {rx_sh_q, 16'h0000};
                                    else if (rx_cnt_q == 2'h1)
                                        rx_bytes_q[15:8] <= rx_sh_q;
                                    else
                                        rx_bytes_q[7:0] <= rx_sh_q;
                                end
                                sda_oe_q <= 1'b1;
                                state_q  <= ST_RX_ACK;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            if (nack_q) begin
                                tx_sh_q   <= status_byte;
                                sda_oe_q  <= ~status_byte[7];
                                bit_cnt_q <= 4'h1;
                                rd_idx_q  <= 3'h1;
                                state_q   <= ST_TX;
                            end else begin
                                sda_oe_q  <= 1'b0;
                                wr_seen_q <= 1'b1;
                                state_q   <= ST_RX;
                            end
                        end
                    end
                    ST_RX_ACK: begin
                        if (scl_fall) begin
                            sda_oe_q <= 1'b0;
                            state_q  <= ST_RX;
                        end
                    end
                    ST_TX: begin
                        // Shift out most significant bit first
                        if (scl_fall) begin
                            if (bit_cnt_q == 4'h8) begin
                                sda_oe_q <= 1'b0;
                                state_q  <= ST_TX_ACK;
                            end else begin
                                tx_sh_q   <= {tx_sh_q[6:0], 1'b0};
                                sda_oe_q  <= ~tx_sh_q[6];
                                bit_cnt_q <= bit_cnt_q + 4'h1;
                            end
                        end
                    end
                    ST_TX_ACK: begin
                        if (scl_rise) begin
                            nack_q <= sda_s;
                        end else if (scl_fall) begin
                            if (nack_q) begin
                                state_q <= ST_IDLE;
                            end else begin
                                tx_sh_q   <= next_byte;
                                sda_oe_q  <= ~next_byte[7];
                                bit_cnt_q <= 4'h1;
                                if (rd_idx_q != 3'h7)
                                    rd_idx_q <= rd_idx_q + 3'h1;
                                state_q   <= ST_TX;
                            end
                        end
                    end
                    default: begin
                        sda_oe_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Density stream on its own pin
    srop_pdm #(.WIDTH(`SROP_DENS_WIDTH)) u_pdm (
        .clock  (clock),
        .resetn (resetn),
        .enable (dens_en_q),
        .level  (dens_level_q),
        .pdm_q  (density_out)
    );

endmodule

`default_nettype wire

/* dv/srop_checker.sv */
// Checker for the result output port: bus, command and density relations.
// Assumes it is bound to srop_top and the core answers with result_valid.
`timescale 1ns/100ps
`default_nettype none

module srop_checker (
    // Clock and reset
    input wire logic        clock,
    input wire logic        resetn,
    // Bus pins
    input wire logic        scl_in,
    input wire logic        sda_in,
    input wire logic        sda_out_q,
    input wire logic        sda_oe_q,
    // Configuration and core
    input wire logic [15:0] cfg_word,
    input wire logic        result_valid,
    input wire logic        cmd_valid_q,
    input wire logic [7:0]  cmd_code_q,
    input wire logic        cyclic_req_q,
    input wire logic        sleep_inhibit_q,
    input wire logic        density_out
);
    logic       busy_q;
    logic       sda_prev_q;
    logic [3:0] since_stop_q;

    default clocking @(posedge clock);
    endclocking
    default disable iff (!resetn);

    // Busy from command to result; age of the last raw STOP
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            busy_q       <= 1'b0;
            sda_prev_q   <= 1'b1;
            since_stop_q <= 4'hF;
        end else begin
            sda_prev_q <= sda_in;
            if (cmd_valid_q) begin
                busy_q <= 1'b1;
            end else if (result_valid) begin
                busy_q <= 1'b0;
            end
            if (scl_in && sda_in && !sda_prev_q) begin
                since_stop_q <= 4'h0;
            end else if (since_stop_q != 4'hF) begin
                since_stop_q <= since_stop_q + 4'h1;
            end
        end
    end

    sequence s_reset_release;
        $rose(resetn) ##2 1'b1;
    endsequence
    sequence s_density_off;
        !cyclic_req_q ##1 !cyclic_req_q;
    endsequence

    a_open_drain: assert property (sda_out_q == 1'b0)
        else $error("data pin driven high");
    a_cmd_single: assert property (cmd_valid_q |=> !cmd_valid_q)
        else $error("command pulse longer than one cycle");
    a_cmd_not_busy: assert property (cmd_valid_q |-> !busy_q)
        else $error("command issued while busy");
    a_cmd_after_stop: assert property (
        cmd_valid_q |-> since_stop_q inside {[4'h1:4'h6]})
        else $error("command not tied to a stop");
    a_code_holds: assert property (!cmd_valid_q |-> $stable(cmd_code_q))
        else $error("command code moved without command");
    a_oe_high_stable: assert property (
        scl_in && $past(scl_in) |-> $stable(sda_oe_q))
        else $error("data enable changed with bus clock high");
    a_density_off: assert property (s_density_off |-> !density_out)
        else $error("density stream active while disabled");
    a_mode_pair: assert property (cyclic_req_q == sleep_inhibit_q)
        else $error("cyclic and sleep inhibit differ");
    a_reset_config: assert property (
        s_reset_release |-> cyclic_req_q == cfg_word[9])
        else $error("density enable not taken after reset");
endmodule

bind srop_top srop_checker u_srop_checker (
    .clock(clock), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .cfg_word(cfg_word),
    .result_valid(result_valid), .cmd_valid_q(cmd_valid_q),
    .cmd_code_q(cmd_code_q), .cyclic_req_q(cyclic_req_q),
    .sleep_inhibit_q(sleep_inhibit_q), .density_out(density_out)
);
`default_nettype wire

/* dv/srop_master.sv */
// Bus master model: drives the bus clock and data, releases data to pull-up.
// Assumes the slave pulls data low only through its output enable.
`timescale 1ns/100ps
`default_nettype none

module srop_master (
    // Clock
    input  wire logic clock,
    // Bus
    input  wire logic sda_oe,
    output wire logic scl,
    output wire logic sda
);
    logic scl_q = 1'b1;
    logic sda_m = 1'b1;

    // Released line reads high through the pull-up
    assign sda = sda_m & ~sda_oe;
    assign scl = scl_q;

    task automatic ph(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic start();
        ph(2);
        sda_m = 1'b0;
        ph(4);
        scl_q = 1'b0;
    endtask

    task automatic stop();
        ph(2);
        sda_m = 1'b0;
        ph(2);
        scl_q = 1'b1;
        ph(4);
        sda_m = 1'b1;
        ph(8);
    endtask

    // Data moves only in the low phase; sampled late in the high phase
    task automatic bit_io(input logic b, output logic r);
        ph(2);
        sda_m = b;
        ph(2);
        scl_q = 1'b1;
        ph(3);
        r = sda;
        ph(1);
        scl_q = 1'b0;
    endtask

    task automatic byte_io(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r[i]);
        end
    endtask

    task automatic wr(input logic [6:0] a, input int n, input logic [23:0] d,
                      output logic ack);
        logic [7:0] r;
        logic       k;
        start();
        byte_io({a, 1'b0}, r);
        bit_io(1'b1, k);
        ack = ~k;
        for (int i = 0; i < n; i++) begin
            byte_io(d[23-8*i -: 8], r);
            bit_io(1'b1, k);
        end
        stop();
    endtask

    task automatic rd(input logic [6:0] a, input int n, output logic [55:0] q);
        logic [7:0] r;
        logic       k;
        q = 56'h0;
        start();
        byte_io({a, 1'b1}, r);
        bit_io(1'b1, k);
        for (int i = 0; i <= n; i++) begin
            byte_io(8'hFF, r);
            q = {q[47:0], r};
            bit_io(i == n, k);
        end
        stop();
    endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the result output port.
// Assumes the master model carries bus traffic; the bench stands in for core.
`timescale 1ns/100ps
`default_nettype none

`define CHK(what, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
        end \
    end

module tb_top;
    typedef struct packed {
        logic [7:0]  cmd;
        logic [25:0] sens;
        logic [25:0] temp;
        logic [23:0] raw;
        logic        cap;
        logic        sat;
        logic [7:0]  st;
        logic [47:0] data;
    } srop_row_t;
    localparam logic [6:0] slave_addr = 7'h29;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    wire logic   scl;
    wire logic   sda;
    logic        sda_out_q;
    logic        sda_oe_q;
    logic [15:0] cfg_word = 16'h0029;
    logic [1:0]  core_mode = 2'h0;
    logic        mem_error = 1'b0;
    logic [1:0]  adc_bits = 2'h0;
    logic        result_valid = 1'b0;
    logic [25:0] sensor_value = 26'h0;
    logic [25:0] temp_value = 26'h0;
    logic [23:0] adc_raw = 24'h0;
    logic        raw_is_cap = 1'b0;
    logic        core_sat = 1'b0;
    logic        cmd_valid_q;
    logic [7:0]  cmd_code_q;
    logic [15:0] cmd_arg_q;
    logic        cyclic_req_q;
    logic        sleep_inhibit_q;
    logic        density_out;
    int          fail_count = 0;
    int          comparisons = 0;
    int          cmd_count = 0;
    srop_row_t   rows [5];

    srop_top u_srop_top (
        .clock(clock), .resetn(resetn), .scl_in(scl), .sda_in(sda),
        .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .cfg_word(cfg_word),
        .core_mode(core_mode), .mem_error(mem_error), .adc_bits(adc_bits),
        .result_valid(result_valid), .sensor_value(sensor_value),
        .temp_value(temp_value), .adc_raw(adc_raw), .raw_is_cap(raw_is_cap),
        .core_sat(core_sat), .cmd_valid_q(cmd_valid_q),
        .cmd_code_q(cmd_code_q), .cmd_arg_q(cmd_arg_q),
        .cyclic_req_q(cyclic_req_q), .sleep_inhibit_q(sleep_inhibit_q),
        .density_out(density_out)
    );
    srop_master u_srop_master (
        .clock(clock), .sda_oe(sda_oe_q), .scl(scl), .sda(sda)
    );

    always #25 clock = ~clock;
    // Mid-cycle count avoids racing the command register
    always @(negedge clock) if (cmd_valid_q === 1'b1) cmd_count++;

    task automatic give_verdict();
        if (fail_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic do_reset(input logic [15:0] cfg);
        @(posedge clock);
        #1;
        resetn = 1'b0;
        cfg_word = cfg;
        repeat (10) @(posedge clock);
        #1;
        resetn = 1'b1;
        repeat (3) @(posedge clock);
        #1;
    endtask

    task automatic core_result(input srop_row_t r);
        @(posedge clock);
        #1;
        {sensor_value, temp_value, adc_raw} = {r.sens, r.temp, r.raw};
        {raw_is_cap, core_sat, result_valid} = {r.cap, r.sat, 1'b1};
        @(posedge clock);
        #1;
        result_valid = 1'b0;
    endtask

    task automatic run_row(input srop_row_t r);
        logic        ack;
        logic [55:0] q;
        u_srop_master.wr(slave_addr, 1, {r.cmd, 16'h0}, ack);
        `CHK("ack", 1'b1, ack)
        `CHK("code", r.cmd, cmd_code_q)
        u_srop_master.rd(slave_addr, 6, q);
        `CHK("busy status", 3'b011, q[55:53])
        `CHK("stale data", 48'h0, q[47:0])
        core_result(r);
        u_srop_master.rd(slave_addr, 6, q);
        `CHK("reply", {r.st, r.data}, q)
        u_srop_master.rd(slave_addr, 6, q);
        `CHK("repeat", {r.st, r.data}, q)
    endtask

    initial begin
        logic        ack;
        logic [55:0] q;
        int          n0;
        int          ones;
        rows[0] = '{8'hAA, 26'h0123456, 26'h0ABCDEF, 24'h0, 1'b0, 1'b0,
                    8'h40, 48'h123456ABCDEF};
        rows[1] = '{8'hAA, 26'h3FFFFFF, 26'h1000000, 24'h0, 1'b0, 1'b0,
                    8'h41, 48'h000000FFFFFF};
        rows[2] = '{8'hA2, 26'h0000800, 26'h0, 24'h000800, 1'b1, 1'b0,
                    8'h42, 48'h000800000000};
        rows[3] = '{8'hA6, 26'h0000123, 26'h0, 24'h000800, 1'b0, 1'b1,
                    8'h41, 48'h000123000000};
        rows[4] = '{8'h51, 26'h0654321, 26'h0, 24'h0, 1'b0, 1'b1,
                    8'h40, 48'h654321000000};
        do_reset(16'h0029);
        foreach (rows[i]) run_row(rows[i]);
        // Command while busy is dropped; extra argument bytes kept
        n0 = cmd_count;
        u_srop_master.wr(slave_addr, 3, 24'hAA1234, ack);
        `CHK("argument", 16'h1234, cmd_arg_q)
        u_srop_master.wr(slave_addr, 1, 24'hA20000, ack);
        `CHK("dropped", n0 + 1, cmd_count)
        `CHK("held code", 8'hAA, cmd_code_q)
        // At 14 bits a raw 800h capacitive value is in range: no overflow
        adc_bits = 2'h1;
        core_result('{8'hAA, 26'h0800000, 26'h0, 24'h800, 1'b1, 1'b0,
                      8'h0, 48'h0});
        u_srop_master.wr(slave_addr ^ 7'h01, 1, 24'hAA0000, ack);
        `CHK("foreign ack", 1'b0, ack)
        `CHK("foreign cmd", n0 + 1, cmd_count)
        for (int m = 0; m < 3; m++) begin
            core_mode = m[1:0];
            mem_error = m[0];
            u_srop_master.rd(slave_addr, 0, q);
            `CHK("status", {3'b010, m[1:0], m[0], 2'b00}, q[7:0])
        end
        // New address and density enable taken after reset
        do_reset(16'h023A);
        `CHK("cyclic", 2'b11, {cyclic_req_q, sleep_inhibit_q})
        u_srop_master.wr(slave_addr, 1, 24'hAA0000, ack);
        `CHK("old address", 1'b0, ack)
        u_srop_master.wr(7'h3A, 1, 24'hAA0000, ack);
        `CHK("new address", 1'b1, ack)
        core_result('{8'hAA, 26'h0800000, 26'h0, 24'h0, 1'b0, 1'b0,
                      8'h0, 48'h0});
        ones = 0;
        repeat (4) @(posedge clock);
        repeat (64) begin
            @(posedge clock);
            #1;
            if (density_out === 1'b1) ones++;
        end
        `CHK("density", 32, ones)
        give_verdict();
    end

    initial begin
        #2000000;
        fail_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
